/* File: shared/rst_seq_pkg.sv */
// constants and types shared by the reset sequencer and watchdog
//
// Overview of operation
// - four sources; pin/power share normal vector
// - hold reset 4064 cycles after power-up
// - stay in reset while pin low
// - drive reset pin low four cycles
// - sample pin two cycles after release
// - enabled watchdog timeout starts system reset
// - disable bit acts only after reset
// - special modes inhibit watchdog until cleared
// - two-bit rate field picks timeout divisor
// - rate field resets to shortest timeout
// - normal mode: one rate write, 64 cycles
// - reset reinitialises control, selects vector
// - fixed two-to-fifteen prescale before watchdog
// - arm then clear value services watchdog
package rst_seq_pkg;

  // ----------------------------------------------------------------
  // timing counts, in bus clock cycles
  // ----------------------------------------------------------------
  localparam int unsigned POR_DELAY_CYC  = 4064;
  localparam int unsigned PIN_DRIVE_CYC  = 4;
  localparam int unsigned PIN_SETTLE_CYC = 2;
  localparam int unsigned SYNC_LAG_CYC   = 3; // pin to third flop output
  localparam int unsigned RATE_WIN_CYC   = 64;
  localparam int unsigned PRESCALE_LOG2  = 15;

  // ----------------------------------------------------------------
  // service values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SVC_ARM_VAL   = 8'h55;
  localparam logic [7:0] SVC_CLEAR_VAL = 8'haa;
  localparam logic [1:0] RATE_RST_VAL  = 2'h0;

  // ----------------------------------------------------------------
  // reset vectors, normal and special modes
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_NORM_PIN = 16'hfffe;
  localparam logic [15:0] VEC_NORM_CLK = 16'hfffc;
  localparam logic [15:0] VEC_NORM_WDG = 16'hfffa;
  localparam logic [15:0] VEC_SPEC_PIN = 16'hbffe;
  localparam logic [15:0] VEC_SPEC_CLK = 16'hbffc;
  localparam logic [15:0] VEC_SPEC_WDG = 16'hbffa;

  typedef enum logic [1:0] {
    CAUSE_POWER = 2'h0,
    CAUSE_PIN   = 2'h1,
    CAUSE_CLK   = 2'h2,
    CAUSE_WDG   = 2'h3
  } cause_t;

  typedef enum logic [5:0] {
    ST_POR    = 6'h01,
    ST_DRIVE  = 6'h02,
    ST_SETTLE = 6'h04,
    ST_SAMPLE = 6'h08,
    ST_HOLD   = 6'h10,
    ST_RUN    = 6'h20
  } seq_state_t;

  typedef struct packed {
    cause_t      cause;
    logic        external;
    logic        wdog_active;
    logic [1:0]  rate;
    logic [15:0] vector;
  } rst_status_t;

endpackage

/* File: rtl/reset_source_and_watchdog.sv */
// reset sequencer with pin source detection and software watchdog
module reset_source_and_watchdog #(
  parameter int unsigned POR_CYC   = rst_seq_pkg::POR_DELAY_CYC,
  parameter int unsigned PRESC_LOG = rst_seq_pkg::PRESCALE_LOG2
) (
  input  wire logic                     mclk_i,        // bus clock
  input  wire logic                     rst_i,         // power-on reset, async high
  input  wire logic                     ce_i,          // clock enable
  input  wire logic                     rst_pin_i,     // reset pin level
  output logic                          rst_pin_o,     // reset pin drive value
  output logic                          rst_pin_oe_o,  // reset pin drive enable
  input  wire logic                     clk_fail_i,    // clock monitor failure
  input  wire logic                     special_i,     // test or bootstrap mode
  input  wire logic                     wdog_disable_bit_i, // nonvolatile disable
  input  wire logic                     svc_wr_i,      // service register write
  input  wire logic [7:0]               svc_data_i,    // service write data
  input  wire logic                     rate_wr_i,     // rate field write
  input  wire logic [1:0]               rate_data_i,   // rate write data
  input  wire logic                     inhibit_wr_i,  // inhibit bit write
  input  wire logic                     inhibit_data_i,// inhibit write data
  output logic                          sys_rst_o,     // core held in reset
  output rst_seq_pkg::rst_status_t      status_o       // cause, vector, state
);

  // ----------------------------------------------------------------
  // pin and clock monitor synchronisers
  // ----------------------------------------------------------------
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;
  logic pin_lvl_r;
  logic clk_s1_r;
  logic clk_s2_r;
  logic clk_s3_r;
  logic clk_lvl_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_r  <= 1'b1;
      pin_s2_r  <= 1'b1;
      pin_s3_r  <= 1'b1;
      pin_lvl_r <= 1'b1;
    end else if (ce_i) begin
      pin_s1_r <= rst_pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r) begin
        pin_lvl_r <= pin_s3_r;
      end
    end
  end

  // clock monitor may come from its own rc timing, so it is synchronised too
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_s1_r  <= 1'b0;
      clk_s2_r  <= 1'b0;
      clk_s3_r  <= 1'b0;
      clk_lvl_r <= 1'b0;
    end else if (ce_i) begin
      clk_s1_r <= clk_fail_i;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      if (clk_s2_r == clk_s3_r) begin
        clk_lvl_r <= clk_s3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // reset sequence
  // ----------------------------------------------------------------
  // settle stretched by the synchroniser lag, so stage 3 shows the pin two cycles after release
  localparam int unsigned SETTLE_END =
    rst_seq_pkg::PIN_SETTLE_CYC + rst_seq_pkg::SYNC_LAG_CYC - 1;

  rst_seq_pkg::seq_state_t state_r;
  rst_seq_pkg::cause_t     cause_r;
  logic [11:0]             seq_cnt_r;
  logic                    ext_r;
  logic                    wdog_fire;
  logic                    running;

  assign running = (state_r == rst_seq_pkg::ST_RUN);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r   <= rst_seq_pkg::ST_POR;
      cause_r   <= rst_seq_pkg::CAUSE_POWER;
      seq_cnt_r <= 12'h000;
      ext_r     <= 1'b0;
    end else if (ce_i) begin
      case (state_r)
        rst_seq_pkg::ST_POR: begin
          // settle time for clock generation
          if (seq_cnt_r == 12'(POR_CYC - 1)) begin
            seq_cnt_r <= 12'h000;
            state_r   <= rst_seq_pkg::ST_DRIVE;
          end else begin
            seq_cnt_r <= seq_cnt_r + 12'h001;
          end
        end
        rst_seq_pkg::ST_DRIVE: begin
          if (seq_cnt_r == 12'(rst_seq_pkg::PIN_DRIVE_CYC - 1)) begin
            seq_cnt_r <= 12'h000;
            state_r   <= rst_seq_pkg::ST_SETTLE;
          end else begin
            seq_cnt_r <= seq_cnt_r + 12'h001;
          end
        end
        rst_seq_pkg::ST_SETTLE: begin
          // pull-up outside gets two cycles to bring the line high
          if (seq_cnt_r == 12'(SETTLE_END)) begin
            seq_cnt_r <= 12'h000;
            state_r   <= rst_seq_pkg::ST_SAMPLE;
          end else begin
            seq_cnt_r <= seq_cnt_r + 12'h001;
          end
        end
        rst_seq_pkg::ST_SAMPLE: begin
          // stage 3 taken raw: the filtered level would lag one more cycle
          ext_r <= ~pin_s3_r;
          if (~pin_s3_r && cause_r != rst_seq_pkg::CAUSE_POWER) begin
            cause_r <= rst_seq_pkg::CAUSE_PIN;
          end
          state_r <= rst_seq_pkg::ST_HOLD;
        end
        rst_seq_pkg::ST_HOLD: begin
          if (pin_lvl_r) begin
            state_r <= rst_seq_pkg::ST_RUN;
          end
        end
        rst_seq_pkg::ST_RUN: begin
          // priority: pin, clock monitor, watchdog
          if (!pin_lvl_r) begin
            cause_r <= rst_seq_pkg::CAUSE_PIN;
            state_r <= rst_seq_pkg::ST_DRIVE;
          end else if (clk_lvl_r) begin
            cause_r <= rst_seq_pkg::CAUSE_CLK;
            state_r <= rst_seq_pkg::ST_DRIVE;
          end else if (wdog_fire) begin
            cause_r <= rst_seq_pkg::CAUSE_WDG;
            state_r <= rst_seq_pkg::ST_DRIVE;
          end
          seq_cnt_r <= 12'h000;
        end
        default: begin
          state_r <= rst_seq_pkg::ST_POR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive and core reset
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_pin_o    <= 1'b0;
      rst_pin_oe_o <= 1'b0;
      sys_rst_o    <= 1'b1;
    end else if (ce_i) begin
      rst_pin_o <= 1'b0;
      // registered, so the pin drive trails the state by one cycle
      rst_pin_oe_o <= (state_r == rst_seq_pkg::ST_DRIVE);
      sys_rst_o    <= ~running | (running & (~pin_lvl_r | clk_lvl_r | wdog_fire));
    end
  end

  // ----------------------------------------------------------------
  // mode, disable latch and inhibit bit
  // ----------------------------------------------------------------
  logic special_r;
  logic nv_dis_r;
  logic inhibit_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      special_r <= 1'b0;
      nv_dis_r  <= 1'b1;
      inhibit_r <= 1'b1;
    end else if (ce_i) begin
      if (!running) begin
        // caught only during reset, so later changes wait for the next one
        special_r <= special_i;
        nv_dis_r  <= wdog_disable_bit_i;
        inhibit_r <= special_i;
      end else if (inhibit_wr_i && !inhibit_data_i) begin
        inhibit_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // rate field with write-once window in normal mode, writable any time in special mode
  // ----------------------------------------------------------------
  logic [1:0] rate_r;
  logic [6:0] win_cnt_r;
  logic       rate_done_r;
  logic       win_open;

  assign win_open = (win_cnt_r < 7'(rst_seq_pkg::RATE_WIN_CYC));

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rate_r      <= rst_seq_pkg::RATE_RST_VAL;
      win_cnt_r   <= 7'h00;
      rate_done_r <= 1'b0;
    end else if (ce_i) begin
      if (!running) begin
        rate_r      <= rst_seq_pkg::RATE_RST_VAL;
        win_cnt_r   <= 7'h00;
        rate_done_r <= 1'b0;
      end else begin
        if (win_open) begin
          win_cnt_r <= win_cnt_r + 7'h01;
        end
        if (rate_wr_i) begin
          if (special_r) begin
            rate_r <= rate_data_i;
          end else if (win_open && !rate_done_r) begin
            rate_r      <= rate_data_i;
            rate_done_r <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog timer
  // ----------------------------------------------------------------
  logic                 wdog_act;
  logic [PRESC_LOG-1:0] presc_r;
  logic [5:0]           wdog_cnt_r;
  logic [5:0]           wdog_lim;
  logic                 armed_r;
  logic                 svc_clear;
  logic                 tick;

  assign wdog_act  = ~nv_dis_r & ~inhibit_r;
  assign tick      = (presc_r == {PRESC_LOG{1'b1}});
  assign svc_clear = svc_wr_i & (svc_data_i == rst_seq_pkg::SVC_CLEAR_VAL) & armed_r;
  assign wdog_fire = running & wdog_act & tick & (wdog_cnt_r == wdog_lim) & ~svc_clear;

  // divisor 2^15 times 1, 4, 16 or 64
  always_comb begin
    case (rate_r)
      2'h0:    wdog_lim = 6'h00;
      2'h1:    wdog_lim = 6'h03;
      2'h2:    wdog_lim = 6'h0f;
      default: wdog_lim = 6'h3f;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_r <= 1'b0;
    end else if (ce_i) begin
      if (!running) begin
        armed_r <= 1'b0;
      end else if (svc_wr_i) begin
        // any other value leaves the arm state alone
        if (svc_data_i == rst_seq_pkg::SVC_ARM_VAL) begin
          armed_r <= 1'b1;
        end else if (svc_data_i == rst_seq_pkg::SVC_CLEAR_VAL) begin
          armed_r <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      presc_r    <= '0;
      wdog_cnt_r <= 6'h00;
    end else if (ce_i) begin
      if (!running || !wdog_act || svc_clear) begin
        presc_r    <= '0;
        wdog_cnt_r <= 6'h00;
      end else begin
        presc_r <= presc_r + 1'b1;
        if (tick) begin
          wdog_cnt_r <= (wdog_cnt_r == wdog_lim) ? 6'h00 : wdog_cnt_r + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status and reset vector
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      status_o <= '{cause: rst_seq_pkg::CAUSE_POWER, external: 1'b0, wdog_active: 1'b0,
                    rate: rst_seq_pkg::RATE_RST_VAL, vector: rst_seq_pkg::VEC_NORM_PIN};
    end else if (ce_i) begin
      status_o.cause       <= cause_r;
      status_o.external    <= ext_r;
      status_o.wdog_active <= wdog_act & running;
      status_o.rate        <= rate_r;
      case (cause_r)
        rst_seq_pkg::CAUSE_CLK:
          status_o.vector <= special_r ? rst_seq_pkg::VEC_SPEC_CLK : rst_seq_pkg::VEC_NORM_CLK;
        rst_seq_pkg::CAUSE_WDG:
          status_o.vector <= special_r ? rst_seq_pkg::VEC_SPEC_WDG : rst_seq_pkg::VEC_NORM_WDG;
        default:
          status_o.vector <= special_r ? rst_seq_pkg::VEC_SPEC_PIN : rst_seq_pkg::VEC_NORM_PIN;
      endcase
    end
  end

endmodule

/* File: sim/rst_seq_props.sv */
// concurrent checks on the reset sequencer ports
module rst_seq_props #(
  parameter int unsigned POR_CYC   = 4064,
  parameter int unsigned PRESC_LOG = 15
) (
  input wire logic                     mclk_i,       // bus clock
  input wire logic                     rst_i,        // power-on reset
  input wire logic                     rst_pin_i,    // pin level
  input wire logic                     rst_pin_o,    // pin drive value
  input wire logic                     rst_pin_oe_o, // pin drive enable
  input wire logic                     clk_fail_i,   // clock monitor failure
  input wire logic                     rate_wr_i,    // rate write strobe
  input wire logic [1:0]               rate_data_i,  // rate write data
  input wire logic                     sys_rst_o,    // core reset
  input wire rst_seq_pkg::rst_status_t status_o      // status
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // cycles since power-on release, saturating
  // ---------------------------------------------------------------
  logic [12:0] age_r;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) age_r <= 13'h0;
    else if (age_r != 13'h1fff) age_r <= age_r + 13'h1;
  end

  por_hold_a: assert property ((age_r < POR_CYC) |-> sys_rst_o && !rst_pin_oe_o)
    else $error("reset left during power-on delay");
  drive_len_a: assert property ($rose(rst_pin_oe_o) |-> rst_pin_oe_o[*4] ##1 !rst_pin_oe_o)
    else $error("pin drive not four cycles");
  drive_low_a: assert property (rst_pin_oe_o |-> !rst_pin_o && sys_rst_o)
    else $error("pin driven high or core running");
  clk_detect_a: assert property ($rose(clk_fail_i) && !sys_rst_o |-> ##[2:9] $rose(rst_pin_oe_o))
    else $error("clock failure did not drive pin");
  pin_detect_a: assert property ($fell(rst_pin_i) && !sys_rst_o |-> ##[1:7] sys_rst_o)
    else $error("low pin did not start reset");
  pin_hold_a: assert property (sys_rst_o && !rst_pin_i |=> sys_rst_o)
    else $error("core released while pin low");
  rate_src_a: assert property ($changed(status_o.rate) && status_o.rate != 2'h0
    |-> $past(rate_wr_i, 2) && status_o.rate == $past(rate_data_i, 2))
    else $error("rate changed without write");
  rate_init_a: assert property ($fell(sys_rst_o) |-> status_o.rate == 2'h0)
    else $error("rate not zero after reset");
  vec_map_a: assert property (!sys_rst_o |-> status_o.vector[7:0] ==
    (status_o.cause == rst_seq_pkg::CAUSE_WDG ? 8'hfa :
     status_o.cause == rst_seq_pkg::CAUSE_CLK ? 8'hfc : 8'hfe))
    else $error("vector does not match cause");
endmodule

bind reset_source_and_watchdog rst_seq_props #(.POR_CYC(POR_CYC), .PRESC_LOG(PRESC_LOG)) u_props (
  .mclk_i(mclk_i), .rst_i(rst_i), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
  .rst_pin_oe_o(rst_pin_oe_o), .clk_fail_i(clk_fail_i), .rate_wr_i(rate_wr_i),
  .rate_data_i(rate_data_i), .sys_rst_o(sys_rst_o), .status_o(status_o));

/* File: sim/reset_supervisor.sv */
// external supervisor model on the reset pin
module reset_supervisor (
  input  wire logic mclk_i, // bus clock
  input  wire logic hold_i, // hold the pin low
  input  wire logic slow_i, // rc-like slow rise
  input  wire logic drv_i,  // device pulls pin low
  output logic      low_o   // model pulls pin low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] rc_r = 4'h0;
  // prompt mode lets the line rise at once; slow mode misreads on purpose
  always_ff @(posedge mclk_i) begin
    if (drv_i) rc_r <= slow_i ? 4'h8 : 4'h0;
    else if (rc_r != 4'h0) rc_r <= rc_r - 4'h1;
  end
  assign low_o = hold_i | (rc_r != 4'h0);
endmodule

/* File: sim/tb_reset_source_and_watchdog.sv */
// self-checking bench for the reset sequencer and watchdog
module tb_reset_source_and_watchdog;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned POR = 16;
  logic mclk = 0, rst = 1, ce = 1, clk_fail = 0, spec = 0, dis = 1;
  logic svc_wr = 0, rate_wr = 0, inh_wr = 0, inh_d = 0, hold = 0, slow = 0;
  logic [7:0] svc_d = 8'h0;
  logic [1:0] rate_d = 2'h0;
  logic pin, pin_o, pin_oe, sys_rst, sup_low;
  rst_seq_pkg::rst_status_t st;
  int n_errors = 0, tests_run = 0;

  always #20 mclk = ~mclk;
  // pull-up on the pin; either party may pull it low
  assign pin = !((pin_oe & !pin_o) | sup_low);

  reset_source_and_watchdog #(.POR_CYC(POR), .PRESC_LOG(3)) DUT (
    .mclk_i(mclk), .rst_i(rst), .ce_i(ce), .rst_pin_i(pin), .rst_pin_o(pin_o),
    .rst_pin_oe_o(pin_oe), .clk_fail_i(clk_fail), .special_i(spec),
    .wdog_disable_bit_i(dis), .svc_wr_i(svc_wr), .svc_data_i(svc_d),
    .rate_wr_i(rate_wr), .rate_data_i(rate_d), .inhibit_wr_i(inh_wr),
    .inhibit_data_i(inh_d), .sys_rst_o(sys_rst), .status_o(st));
  reset_supervisor u_sup (.mclk_i(mclk), .hold_i(hold), .slow_i(slow),
    .drv_i(pin_oe & !pin_o), .low_o(sup_low));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wait_rst(input logic v, input int lim);
    for (int i = 0; i < lim && sys_rst !== v; i++) cyc(1);
    chk("sys_rst", 16'(v), 16'(sys_rst));
  endtask
  task automatic boot(input logic s, input logic d);
    spec = s;
    dis = d;
    rst = 1;
    cyc(5);
    rst = 0;
    cyc(POR - 1);
    chk("por_hold", 16'h1, 16'(sys_rst));
    wait_rst(0, 40);
  endtask
  task automatic stat(input logic [1:0] c, input logic x, input logic [15:0] v);
    chk("cause", 16'(c), 16'(st.cause));
    chk("external", 16'(x), 16'(st.external));
    chk("vector", v, st.vector);
  endtask
  task automatic svc(input logic [7:0] d);
    svc_wr = 1;
    svc_d = d;
    cyc(1);
    svc_wr = 0;
    cyc(1);
  endtask
  task automatic rate_w(input logic [1:0] d, input logic [1:0] e);
    rate_wr = 1;
    rate_d = d;
    cyc(1);
    rate_wr = 0;
    cyc(2);
    chk("rate", 16'(e), 16'(st.rate));
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_power();
    boot(0, 1);
    stat(2'h0, 0, 16'hfffe);
    chk("rate0", 16'h0, 16'(st.rate));
    hold = 1;
    rst = 1;
    cyc(2);
    rst = 0;
    cyc(POR + 40);
    chk("pin_low_hold", 16'h1, 16'(sys_rst));
    hold = 0;
    wait_rst(0, 20);
    chk("vector", 16'hfffe, st.vector);
  endtask
  task automatic t_sources();
    boot(0, 1);
    hold = 1;
    cyc(20);
    hold = 0;
    wait_rst(0, 30);
    stat(2'h1, 1, 16'hfffe);
    for (int i = 0; i < 2; i++) begin
      slow = i[0];
      clk_fail = 1;
      cyc(5);
      clk_fail = 0;
      wait_rst(1, 10);
      wait_rst(0, 40);
      chk("external", 16'(i), 16'(st.external));
      chk("vector", i[0] ? 16'hfffe : 16'hfffc, st.vector);
    end
    slow = 0;
  endtask
  task automatic t_rate_timeout();
    boot(0, 0);
    rate_w(2'h2, 2'h2);
    rate_w(2'h3, 2'h2);
    cyc(100);
    chk("no_early", 16'h0, 16'(sys_rst));
    wait_rst(1, 60);
    wait_rst(0, 30);
    stat(2'h3, 0, 16'hfffa);
    chk("rate0", 16'h0, 16'(st.rate));
  endtask
  task automatic t_late_and_disable();
    boot(0, 1);
    chk("active", 16'h0, 16'(st.wdog_active));
    cyc(70);
    rate_w(2'h1, 2'h0);
    dis = 0;
    cyc(60);
    chk("no_reset", 16'h0, 16'(sys_rst));
    chk("active", 16'h0, 16'(st.wdog_active));
  endtask
  task automatic t_service();
    boot(0, 0);
    rate_w(2'h1, 2'h1);
    repeat (6) begin
      cyc(14);
      svc(8'h55);
      svc(8'haa);
    end
    chk("serviced", 16'h0, 16'(sys_rst));
    repeat (2) begin
      cyc(10);
      svc(8'haa);
    end
    wait_rst(1, 30);
  endtask
  task automatic t_special();
    boot(1, 0);
    chk("inhibited", 16'h0, 16'(st.wdog_active));
    cyc(70);
    rate_w(2'h3, 2'h3);
    rate_w(2'h1, 2'h1);
    cyc(40);
    chk("no_reset", 16'h0, 16'(sys_rst));
    inh_wr = 1;
    cyc(1);
    inh_wr = 0;
    cyc(2);
    chk("active", 16'h1, 16'(st.wdog_active));
    ce = 0;
    cyc(40);
    chk("frozen", 16'h0, 16'(sys_rst));
    ce = 1;
    wait_rst(1, 50);
    wait_rst(0, 30);
    chk("vector", 16'hbffa, st.vector);
  endtask

  initial begin
    #(40 * 6000);
    n_errors++;
    test_done();
  end

  initial begin
    t_power();
    t_sources();
    t_rate_timeout();
    t_late_and_disable();
    t_service();
    t_special();
    test_done();
  end
endmodule
